// >>> monitor_readout_regs.svh
// register offsets, field positions, reset values and counts of the monitor readout
`ifndef MONITOR_READOUT_REGS_SVH
`define MONITOR_READOUT_REGS_SVH

// register byte offsets
`define OFS_CONTROL          12'h000
`define OFS_MASK             12'h004
`define OFS_STATUS           12'h008
`define OFS_VOLTAGE_WORD     12'h00C
`define OFS_CURRENT_WORD     12'h010
`define OFS_BATTERY_WORD     12'h014

// control field positions
`define CTL_PDN_LSB          0
`define CTL_GLOBAL_PDN_BIT   3
`define CTL_WINDOW_LSB       4
`define CTL_SDOUT_OFF_BIT    7
`define CTL_WORD12_BIT       8

// flag bit order, shared by mask, status and power-down fields
`define MON_VOLTAGE          0
`define MON_CURRENT          1
`define MON_BATTERY          2
`define STS_UVLO_BIT         3

// reset values
`define RST_PDN              3'h7
`define RST_WINDOW           3'h4
`define RST_MASK             3'h7

// window select: slice msb is this base plus the select value
`define WINDOW_MSB_BASE      18
`define CURRENT_RAW_W        26
`define FRAME_BITS           40

`endif

// >>> monitor_readout_pkg.sv
// types shared by the monitor readout modules
package monitor_readout_pkg;

	typedef logic [2:0] mon_bits_t;

	typedef struct packed {
		mon_bits_t    pdn;
		logic         global_pdn;
		logic [2:0]   window_sel;
		logic         sdout_off;
		logic         word12;
		mon_bits_t    mask;
		mon_bits_t    flags;
		logic [15:0]  volt_word;
		logic [15:0]  curr_word;
		logic [7:0]   batt_word;
		logic [39:0]  frame;
		logic         sclk_prev;
		logic         lrck_prev;
		logic         pready;
		logic         pslverr;
		logic [31:0]  prdata;
		logic         irq;
		logic         sdout;
		logic         sdout_oe;
		mon_bits_t    pdn_pins;
		logic         global_pdn_pin;
	} core_state_s;

endpackage

// >>> current_window_if.sv
// carrier between the core and the current window selector
`timescale 1ns/1ps
interface current_window_if;
	logic [25:0] raw;
	logic [2:0]  sel;
	logic [15:0] word;
	logic        ovfl;

	modport core   (output raw, output sel, input word, input ovfl);
	modport window (input raw, input sel, output word, output ovfl);
endinterface

// >>> level_sync.sv
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module level_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         ref_clk_in,
	input  wire logic         rst_in,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic [W-1:0]      sync_out
);
	typedef struct packed {
		logic [W-1:0] stage2;
		logic [W-1:0] stage1;
	} sync_state_s;

	sync_state_s st;
	sync_state_s next_st;

	// first stage feeds only the second
	always_comb begin
		next_st.stage1 = async_in;
		next_st.stage2 = st.stage1;
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sync_out = st.stage2;
endmodule

// >>> current_window.sv
// picks a 16-bit slice of the wide current result and flags truncation
`timescale 1ns/1ps
`include "monitor_readout_regs.svh"
module current_window (
	current_window_if.window cw
);
	logic signed [25:0] shifted;
	logic [4:0]         shift;
	logic [10:0]        upper;

	// slice lsb sits fifteen below the msb; each select step doubles the weight per code
	always_comb begin
		shift   = 5'(`WINDOW_MSB_BASE - 15) + 5'(cw.sel);
		shifted = $signed(cw.raw) >>> shift;
		upper   = shifted[25:15];
		cw.word = shifted[15:0];
		// upper bits must all copy the slice sign, else the word was cut
		cw.ovfl = ~((&upper) | ~(|upper));
	end
endmodule

// >>> monitor_readout.sv
// apb register file, overflow status and serial frame output of the three monitors
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`include "monitor_readout_regs.svh"

module monitor_readout (
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// converter results, same clock
	input  wire logic        sample_valid_in,
	input  wire logic [15:0] voltage_raw_in,
	input  wire logic        voltage_overrange_in,
	input  wire logic [25:0] current_raw_in,
	input  wire logic [7:0]  battery_raw_in,
	input  wire logic        battery_overrange_in,
	// supply lockout level from the analog side
	input  wire logic        uvlo_in,
	// serial port pins
	input  wire logic        sclk_in,
	input  wire logic        lrck_in,
	output logic             sdout_out,
	output logic             sdout_oe_out,
	// power controls and interrupt
	output logic [2:0]       monitor_power_down_bits_out,
	output logic             global_power_down_out,
	output logic             irq_out
);
	monitor_readout_pkg::core_state_s st;
	monitor_readout_pkg::core_state_s next_st;

	current_window_if cw ();
	logic [2:0] pins_sync;
	logic       sclk_s;
	logic       lrck_s;
	logic       uvlo_s;

	// pins cross into the clock domain through two flops each
	level_sync #(
		.W (3)
	) u_pin_sync (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.async_in   ({uvlo_in, lrck_in, sclk_in}),
		.sync_out   (pins_sync)
	);

	assign sclk_s = pins_sync[0];
	assign lrck_s = pins_sync[1];
	assign uvlo_s = pins_sync[2];

	// window selector sees the raw current and the programmed select
	assign cw.raw = current_raw_in;
	assign cw.sel = st.window_sel;

	current_window u_window (
		.cw (cw)
	);

	logic                           access;
	logic                           wr_now;
	logic                           rd_now;
	logic [2:0]                     overrange;
	logic [2:0]                     live;
	logic [2:0]                     clear_flags;
	logic [15:0]                    low_mask;
	logic [31:0]                    rd_val;
	logic                           rd_ok;

	// bus decode: answer one cycle into the access phase
	always_comb begin
		access = psel_in & penable_in;
		wr_now = access & st.pready & pwrite_in;
		rd_now = access & ~st.pready & ~pwrite_in;
		rd_ok  = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (paddr_in)
			`OFS_CONTROL: begin
				rd_val[`CTL_PDN_LSB +: 3]       = st.pdn;
				rd_val[`CTL_GLOBAL_PDN_BIT]     = st.global_pdn;
				rd_val[`CTL_WINDOW_LSB +: 3]    = st.window_sel;
				rd_val[`CTL_SDOUT_OFF_BIT]      = st.sdout_off;
				rd_val[`CTL_WORD12_BIT]         = st.word12;
			end
			`OFS_MASK: begin
				rd_val[2:0] = st.mask;
			end
			`OFS_STATUS: begin
				rd_val[2:0]           = st.flags;
				rd_val[`STS_UVLO_BIT] = uvlo_s;
			end
			`OFS_VOLTAGE_WORD: begin
				rd_val = {{16{st.volt_word[15]}}, st.volt_word};
			end
			`OFS_CURRENT_WORD: begin
				rd_val = {{16{st.curr_word[15]}}, st.curr_word};
			end
			`OFS_BATTERY_WORD: begin
				rd_val = {{24{st.batt_word[7]}}, st.batt_word};
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	// overrange per path; a powered-down path cannot report
	always_comb begin
		live        = ~st.pdn & {3{~st.global_pdn}};
		overrange[`MON_VOLTAGE] = voltage_overrange_in;
		overrange[`MON_CURRENT] = cw.ovfl;
		overrange[`MON_BATTERY] = battery_overrange_in;
		overrange   = overrange & live & {3{sample_valid_in}};
		clear_flags = (access & st.pready & ~pwrite_in & (paddr_in == `OFS_STATUS))
			? 3'h7 : 3'h0;
		// twelve-bit form keeps only the upper twelve bits
		low_mask    = st.word12 ? 16'hFFF0 : 16'hFFFF;
	end

	// next state of the whole core
	always_comb begin
		next_st = st;

		// register writes take effect at the completing edge
		if (wr_now) begin
			unique case (paddr_in)
				`OFS_CONTROL: begin
					next_st.pdn        = pwdata_in[`CTL_PDN_LSB +: 3];
					next_st.global_pdn = pwdata_in[`CTL_GLOBAL_PDN_BIT];
					next_st.window_sel = pwdata_in[`CTL_WINDOW_LSB +: 3];
					next_st.sdout_off  = pwdata_in[`CTL_SDOUT_OFF_BIT];
					next_st.word12     = pwdata_in[`CTL_WORD12_BIT];
				end
				`OFS_MASK: begin
					next_st.mask = pwdata_in[2:0];
				end
				default: begin
					next_st.mask = st.mask;
				end
			endcase
		end

		// bus answer: ready for one cycle, data and error with it
		next_st.pready  = access & ~st.pready;
		next_st.pslverr = access & ~st.pready & ~rd_ok;
		if (rd_now) begin
			next_st.prdata = rd_val;
		end

		// set wins over the read clear, so a held overflow stays visible
		next_st.flags = (st.flags & ~clear_flags) | overrange;
		next_st.irq   = |(next_st.flags & ~st.mask);

		// capture fresh words unscaled, so full scale keeps its meaning
		// a powered-down path reads zero
		if (sample_valid_in) begin
			next_st.volt_word = live[`MON_VOLTAGE] ? (voltage_raw_in & low_mask) : 16'h0000;
			next_st.curr_word = live[`MON_CURRENT] ? (cw.word & low_mask) : 16'h0000;
			next_st.batt_word = live[`MON_BATTERY] ? battery_raw_in : 8'h00;
		end

		// serial frame: all three words loaded together at each word clock edge
		next_st.sclk_prev = sclk_s;
		next_st.lrck_prev = lrck_s;
		if (lrck_s != st.lrck_prev) begin
			next_st.frame = {st.volt_word, st.curr_word, st.batt_word};
		end else if (st.sclk_prev & ~sclk_s) begin
			next_st.frame = {st.frame[38:0], 1'b0};
		end
		next_st.sdout    = next_st.frame[39];
		// lockout powers the output down so the fault is not echoed back
		next_st.sdout_oe = ~uvlo_s & ~st.sdout_off & ~st.global_pdn;
		// an undriven pin also holds low, so no stale bit waits behind the enable
		if (~next_st.sdout_oe) begin
			next_st.sdout = 1'b0;
		end

		next_st.pdn_pins       = st.pdn;
		next_st.global_pdn_pin = st.global_pdn;
	end

	// one register for the whole core
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			st            <= '0;
			st.pdn        <= `RST_PDN;
			st.window_sel <= `RST_WINDOW;
			st.mask       <= `RST_MASK;
			st.pdn_pins   <= `RST_PDN;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flops
	assign prdata_out                  = st.prdata;
	assign pready_out                  = st.pready;
	assign pslverr_out                 = st.pslverr;
	assign sdout_out                   = st.sdout;
	assign sdout_oe_out                = st.sdout_oe;
	assign monitor_power_down_bits_out = st.pdn_pins;
	assign global_power_down_out       = st.global_pdn_pin;
	assign irq_out                     = st.irq;
endmodule

// >>> monitor_readout_monitor.sv
// port-level assertion checker for the monitor readout
`timescale 1ns/1ps
`include "monitor_readout_regs.svh"
module monitor_readout_monitor (
	// clock and reset
	input wire logic        ref_clk_in,
	input wire logic        rst_in,
	// apb
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	// serial port, lockout, controls
	input wire logic        uvlo_in,
	input wire logic        sdout_out,
	input wire logic        sdout_oe_out,
	input wire logic [2:0]  monitor_power_down_bits_out,
	input wire logic        global_power_down_out,
	input wire logic        irq_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_wait;
		psel_in && penable_in && !pready_out;
	endsequence
	sequence s_ctl_wr;
		psel_in && penable_in && pready_out && pwrite_in && paddr_in == `OFS_CONTROL;
	endsequence

	// recent status or mask accesses, the only things allowed to drop irq
	logic [3:0] clear_hist;
	always_ff @(posedge ref_clk_in) begin
		clear_hist <= rst_in ? 4'h0 : {clear_hist[2:0], psel_in && penable_in && pready_out
			&& (paddr_in == `OFS_STATUS || paddr_in == `OFS_MASK)};
	end

	a_ready_wait: assert property (s_wait |=> pready_out) else $error("pready late");
	a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("pready held");
	a_err_ready: assert property (pslverr_out |-> pready_out) else $error("lone pslverr");
	a_pdn_source: assert property ($changed(monitor_power_down_bits_out) |->
		$past(psel_in && penable_in && pready_out && pwrite_in && paddr_in == `OFS_CONTROL, 2))
		else $error("power-down moved without write");
	a_uvlo_quiet: assert property (uvlo_in[*5] |-> !sdout_oe_out) else $error("sdout in lockout");
	a_global_quiet: assert property (global_power_down_out[*3] |-> !sdout_oe_out)
		else $error("sdout while powered down");
	a_idle_low: assert property (!sdout_oe_out |-> !sdout_out) else $error("sdout not idle");
	a_irq_release: assert property ($fell(irq_out) |-> |clear_hist) else $error("irq dropped");
	a_rdata_hold: assert property ($changed(prdata_out) |-> pready_out && !pwrite_in)
		else $error("prdata moved");
	c_ctl_wr: cover property (s_ctl_wr);
endmodule

bind monitor_readout monitor_readout_monitor monitor_readout_monitor_i (.*);

// >>> sp_host_model.sv
// system processor end of the serial link: makes link clocks, collects frames
`timescale 1ns/1ps
module sp_host_model (
	// link clocks
	output logic      sclk_out,
	output logic      lrck_out,
	// device data
	input  wire logic sdout_in
);
	initial begin
		sclk_out = 1'b0;
		lrck_out = 1'b0;
	end
	// data is taken late in the high phase: the device answers a few of its clocks after a fall
	task automatic grab(output logic [39:0] f);
		#13 lrck_out = ~lrck_out;
		#400;
		for (int i = 0; i < 40; i++) begin
			sclk_out = 1'b1;
			#120 f = {f[38:0], sdout_in};
			#40 sclk_out = 1'b0;
			#160;
		end
	endtask
endmodule

// >>> monitor_readout_tb_top.sv
// self-checking bench for the monitor readout
`timescale 1ns/1ps
`include "monitor_readout_regs.svh"
module monitor_readout_tb_top;
	logic ref_clk_in, rst_in, psel_in, penable_in, pwrite_in, sample_valid_in, uvlo_in;
	logic voltage_overrange_in, battery_overrange_in, sclk_in, lrck_in, er;
	logic pready_out, pslverr_out, sdout_out, sdout_oe_out, global_power_down_out, irq_out;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, rd, lf;
	logic [2:0]  monitor_power_down_bits_out;
	logic [15:0] voltage_raw_in;
	logic [25:0] current_raw_in;
	logic [7:0]  battery_raw_in;
	logic [39:0] fr;
	int          error_cnt = 0;
	int          check_count = 0;

	monitor_readout monitor_readout_i (.*);
	sp_host_model sp_host_model_i (.sclk_out(sclk_in), .lrck_out(lrck_in), .sdout_in(sdout_out));

	always #20 ref_clk_in = ~ref_clk_in;

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected current word and truncation flag for a window select
	function automatic logic [31:0] cw(input logic [25:0] c, input int s);
		logic [15:0] w;
		w = c[18 + s -: 16];
		return {{16{w[15]}}, w};
	endfunction
	function automatic logic ov(input logic [25:0] c, input int s);
		logic [25:0] t;
		t = $signed(c) >>> (18 + s);
		return !(&t || ~|t);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// one apb transfer, entered just after a rising edge, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		// look mid-cycle, where pready and the data it qualifies have settled
		do begin
			@(negedge ref_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			give_verdict();
		end
		rd = prdata_out;
		er = pslverr_out;
		// release after the completing edge, then idle one edge before any next call
		@(posedge ref_clk_in);
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge ref_clk_in);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic smp(input logic [25:0] c, input logic vo);
		lf = nxt(lf);
		sample_valid_in <= 1'b1;
		voltage_raw_in <= lf[15:0];
		battery_raw_in <= lf[23:16];
		current_raw_in <= c;
		voltage_overrange_in <= vo;
		@(posedge ref_clk_in);
		sample_valid_in <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
	endtask

	initial begin
		{ref_clk_in, psel_in, penable_in, pwrite_in, sample_valid_in, uvlo_in} = 6'h00;
		{voltage_overrange_in, battery_overrange_in, paddr_in, pwdata_in} = '0;
		{voltage_raw_in, current_raw_in, battery_raw_in} = '0;
		rst_in = 1'b1;
		lf = 32'h0001_5970;
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(posedge ref_clk_in);
		rchk(`OFS_CONTROL, 32'h0000_0047);
		rchk(`OFS_MASK, 32'h0000_0007);
		apb(1'b0, 12'h020, 32'h0);
		chk({rd[30:0], er}, 32'h0000_0001);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, `OFS_CONTROL, 32'h40 | i);
			repeat (2) @(posedge ref_clk_in);
			chk(monitor_power_down_bits_out, i);
		end
		// every window select, with a wide random value and a small one that fits
		for (int s = 0; s < 8; s++) begin
			apb(1'b1, `OFS_CONTROL, s << 4);
			apb(1'b0, `OFS_STATUS, 32'h0);
			for (int k = 0; k < 2; k++) begin
				lf = nxt(lf);
				fr[25:0] = k ? {{13{lf[12]}}, lf[12:0]} : lf[25:0];
				smp(fr[25:0], lf[31]);
				rchk(`OFS_CURRENT_WORD, cw(fr[25:0], s));
				rchk(`OFS_VOLTAGE_WORD, {{16{voltage_raw_in[15]}}, voltage_raw_in});
				rchk(`OFS_BATTERY_WORD, {{24{battery_raw_in[7]}}, battery_raw_in});
				rchk(`OFS_STATUS, {30'h0, ov(fr[25:0], s), voltage_overrange_in});
			end
		end
		// a too-narrow window overflows; raising the select stops it
		apb(1'b1, `OFS_CONTROL, 32'h0);
		smp(26'h100_0000, 1'b0);
		rchk(`OFS_STATUS, 32'h2);
		apb(1'b1, `OFS_CONTROL, 32'h70);
		smp(26'h100_0000, 1'b0);
		rchk(`OFS_STATUS, 32'h0);
		// unmasked flag raises irq, which holds until the status read
		apb(1'b1, `OFS_MASK, 32'h0);
		smp(26'h0, 1'b1);
		chk(irq_out, 1'b1);
		smp(26'h0, 1'b0);
		chk(irq_out, 1'b1);
		rchk(`OFS_STATUS, 32'h1);
		smp(26'h0, 1'b0);
		chk(irq_out, 1'b0);
		battery_overrange_in <= 1'b1;
		smp(26'h0, 1'b0);
		battery_overrange_in <= 1'b0;
		chk(irq_out, 1'b1);
		rchk(`OFS_STATUS, 32'h4);
		// frame out of the serial port, full and in 12-bit form
		apb(1'b1, `OFS_CONTROL, 32'h40);
		smp(26'h12_3456, 1'b0);
		sp_host_model_i.grab(fr);
		chk(fr[39:8], {voltage_raw_in, current_raw_in[22:7]});
		chk(fr[7:0], battery_raw_in);
		@(posedge ref_clk_in);
		apb(1'b1, `OFS_CONTROL, 32'h140);
		smp(26'h0, 1'b0);
		sp_host_model_i.grab(fr);
		chk(fr[39:24], {voltage_raw_in[15:4], 4'h0});
		@(posedge ref_clk_in);
		uvlo_in <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		chk(sdout_oe_out, 1'b0);
		uvlo_in <= 1'b0;
		apb(1'b1, `OFS_CONTROL, 32'hC0);
		repeat (6) @(posedge ref_clk_in);
		chk({sdout_oe_out, sdout_out}, 32'h0);
		apb(1'b1, `OFS_CONTROL, 32'h48);
		repeat (6) @(posedge ref_clk_in);
		chk({global_power_down_out, sdout_oe_out}, 32'h2);
		give_verdict();
	end
endmodule
